// ==== verilog/i2c_slave_pkg.sv ====
package i2c_slave_pkg;
    localparam int APB_AW = 8;
    localparam int EV_N = 5;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_ADDR = 8'h0C;
    localparam logic [7:0] OFF_ALT = 8'h10;
    localparam logic [7:0] OFF_RXD = 8'h14;
    localparam logic [7:0] OFF_TXD = 8'h18;

    // slave_control_reg field positions
    localparam int CTL_SLAVE_ENABLE = 0;
    localparam int CTL_TEN_BIT_ADDR_EN = 1;
    localparam int CTL_GENCALL_EN = 2;
    localparam int CTL_HW_GENCALL_EN = 3;
    localparam int CTL_GENCALL_STATUS_CLEAR = 4;
    localparam int CTL_EARLY_TX_REQUEST = 5;
    localparam int CTL_FORCE_NO_ACK = 7;
    localparam int CTL_STOP_DETECT_IRQ_EN = 8;
    localparam int CTL_SLAVE_RX_IRQ_EN = 9;
    localparam int CTL_SLAVE_TX_IRQ_EN = 10;
    // stored bits: reserved 6, 15:11 and the self-clearing bit 4 read as zero
    localparam logic [15:0] CTL_STORE_MASK = 16'h07AF;
    localparam logic [15:0] CTL_RESET = 16'h0000;

    // event / sticky status bit positions
    localparam int EV_TX_DONE = 0;
    localparam int EV_RX_BYTE = 1;
    localparam int EV_STOP = 2;
    localparam int EV_GENCALL = 3;
    localparam int EV_TX_REQ = 4;
    localparam int STAT_GC = 5;
    localparam int STAT_GC_ID = 6;
    localparam int STAT_BUSY = 8;
    localparam int STAT_READ = 9;

    localparam logic [4:0] MASK_RESET = 5'h00;
    localparam logic [9:0] ADDR_RESET = 10'h050;
    localparam logic [7:0] ALT_RESET = 8'h01;
    localparam int ADDR_PROG_W = 3;

    // bus byte values
    localparam logic [7:0] GC_ADDRESS = 8'h00;
    localparam logic [7:0] GC_RESET_CMD = 8'h06;
    localparam logic [7:0] GC_PROG_CMD = 8'h04;
    localparam logic [4:0] TEN_BIT_HDR = 5'h1E;

    // general call id codes
    localparam logic [1:0] GCID_NONE = 2'h0;
    localparam logic [1:0] GCID_RESET = 2'h1;
    localparam logic [1:0] GCID_PROG = 2'h2;
    localparam logic [1:0] GCID_HW = 2'h3;
endpackage

// ==== verilog/i2c_slave_if.sv ====
`timescale 1ns/1ps
interface i2c_slave_if;
    logic sclRise;
    logic sclFall;
    logic sdaLvl;
    logic startDet;
    logic stopDet;
    logic [4:0] evt;
    logic [4:0] clrMask;
    logic [4:0] mask;
    logic [4:0] status;
    logic irq;

    modport lineSrc(output sclRise, sclFall, sdaLvl, startDet, stopDet);
    modport lineDst(input sclRise, sclFall, sdaLvl, startDet, stopDet);
    modport irqCore(input evt, clrMask, mask, output status, irq);
    modport irqUser(output evt, clrMask, mask, input status, irq);
endinterface

// ==== verilog/i2c_line_sync.sv ====
`timescale 1ns/1ps
module i2c_line_sync (
    input wire logic mclk,    // system clock
    input wire logic rst,     // sync reset, high
    input wire logic sclPin,  // raw scl level
    input wire logic sdaPin,  // raw sda level
    i2c_slave_if.lineSrc ev   // line events
);
    logic sclS1_r;
    logic sclS2_r;
    logic sclS3_r;
    logic sdaS1_r;
    logic sdaS2_r;
    logic sdaS3_r;

    // idle bus is high, so reset to one avoids a false edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            {sclS1_r, sclS2_r, sclS3_r} <= 3'h7;
            {sdaS1_r, sdaS2_r, sdaS3_r} <= 3'h7;
        end else begin
            {sclS1_r, sclS2_r, sclS3_r} <= {sclPin, sclS1_r, sclS2_r};
            {sdaS1_r, sdaS2_r, sdaS3_r} <= {sdaPin, sdaS1_r, sdaS2_r};
        end
    end

    assign ev.sclRise = sclS2_r & ~sclS3_r;
    assign ev.sclFall = ~sclS2_r & sclS3_r;
    assign ev.sdaLvl = sdaS2_r;
    assign ev.startDet = sclS2_r & sclS3_r & sdaS3_r & ~sdaS2_r;
    assign ev.stopDet = sclS2_r & sclS3_r & ~sdaS3_r & sdaS2_r;
endmodule

// ==== verilog/i2c_irq_status.sv ====
`timescale 1ns/1ps
module i2c_irq_status (
    input wire logic mclk,  // system clock
    input wire logic rst,   // sync reset, high
    i2c_slave_if.irqCore ir // events, mask, status
);
    logic [4:0] status_r;
    logic [4:0] status_nxt;
    logic irq_r;

    // set wins over a read clear in the same cycle
    assign status_nxt = (status_r & ~ir.clrMask) | ir.evt;

    always_ff @(posedge mclk) begin
        if (rst) begin
            status_r <= 5'h00;
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_r <= |(status_nxt & ir.mask);
        end
    end

    assign ir.status = status_r;
    assign ir.irq = irq_r;
endmodule

// ==== verilog/i2c_slave_control.sv ====
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - slave works only while enabled
// - address width bit selects 10-bit decode
// - general call address acked, next byte command
// - command 0x06 resets, loads address part
// - command 0x04 sets general call status
// - byte matching alternate id: hardware call
// - clear bit wipes general call status, id
// - early bit moves transmit request edge
// - override bit withholds data byte acknowledge
// - stop detection interrupt when enabled
// - receive byte interrupt when enabled
// - transmit done interrupt when enabled
module i2c_slave_control (
    input wire logic mclk,            // system clock, 100 MHz
    input wire logic rst,             // sync reset, high
    input wire logic psel,            // apb select
    input wire logic penable,         // apb enable
    input wire logic pwrite,          // apb direction
    input wire logic [7:0] paddr,     // apb byte address
    input wire logic [31:0] pwdata,   // apb write data
    output logic [31:0] prdata,       // apb read data
    output logic pready,              // apb ready
    output logic pslverr,             // apb error, unmapped
    input wire logic sclIn,           // scl pin level
    input wire logic sdaIn,           // sda pin level
    output logic sdaOut,              // sda drive value, always low
    output logic sdaOe,               // sda pull low enable
    input wire logic [2:0] addrPins,  // programmable address part
    output logic irq                  // level interrupt
);
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_RX = 8'h02,
        ST_ACKW = 8'h04,
        ST_ACKD = 8'h08,
        ST_TX = 8'h10,
        ST_TXACK = 8'h20,
        ST_MACK = 8'h40,
        ST_SKIP = 8'h80
    } state_e;

    typedef enum logic [3:0] {
        PH_ADDR1 = 4'h1,
        PH_ADDR2 = 4'h2,
        PH_GC = 4'h4,
        PH_DATA = 4'h8
    } phase_e;

    i2c_slave_if bus();

    i2c_line_sync uLine (
        .mclk(mclk),
        .rst(rst),
        .sclPin(sclIn),
        .sdaPin(sdaIn),
        .ev(bus.lineSrc)
    );

    i2c_irq_status uIrq (
        .mclk(mclk),
        .rst(rst),
        .ir(bus.irqCore)
    );

    state_e state_r;
    phase_e phase_r;
    logic [15:0] ctrl_r;
    logic [4:0] mask_r;
    logic [9:0] addr_r;
    logic [7:0] alt_r;
    logic [7:0] rxData_r;
    logic [7:0] txData_r;
    logic [7:0] sh_r;
    logic [2:0] bitCnt_r;
    logic ackNow_r;
    logic goTx_r;
    logic goIdle_r;
    logic readMode_r;
    logic tenMatched_r;
    logic txPend_r;
    logic sdaOe_r;
    logic sdaOut_r;
    logic gcStat_r;
    logic [1:0] gcId_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [2:0] pinS1_r;
    logic [2:0] pinS2_r;

    // control fields
    wire slvEn = ctrl_r[i2c_slave_pkg::CTL_SLAVE_ENABLE];
    wire tenEn = ctrl_r[i2c_slave_pkg::CTL_TEN_BIT_ADDR_EN];
    wire gcEn = ctrl_r[i2c_slave_pkg::CTL_GENCALL_EN];
    wire hgcEn = ctrl_r[i2c_slave_pkg::CTL_HW_GENCALL_EN];
    wire early = ctrl_r[i2c_slave_pkg::CTL_EARLY_TX_REQUEST];
    wire forceNoAck = ctrl_r[i2c_slave_pkg::CTL_FORCE_NO_ACK];

    // apb decode
    wire setup = psel & ~penable;
    wire access = psel & penable & pready_r;
    wire selCtrl = paddr == i2c_slave_pkg::OFF_CTRL;
    wire selStat = paddr == i2c_slave_pkg::OFF_STAT;
    wire selMask = paddr == i2c_slave_pkg::OFF_MASK;
    wire selAddr = paddr == i2c_slave_pkg::OFF_ADDR;
    wire selAlt = paddr == i2c_slave_pkg::OFF_ALT;
    wire selRxd = paddr == i2c_slave_pkg::OFF_RXD;
    wire selTxd = paddr == i2c_slave_pkg::OFF_TXD;
    wire hit = selCtrl | selStat | selMask | selAddr | selAlt | selRxd | selTxd;
    wire wrAcc = access & pwrite;
    wire gcClrWr = wrAcc & selCtrl & pwdata[i2c_slave_pkg::CTL_GENCALL_STATUS_CLEAR];

    wire [9:0] statWord = {readMode_r, state_r != ST_IDLE, gcId_r, gcStat_r, bus.status};
    wire [31:0] rdMux = selCtrl ? {16'h0000, ctrl_r} :
                        selStat ? {22'h000000, statWord} :
                        selMask ? {27'h0000000, mask_r} :
                        selAddr ? {22'h000000, addr_r} :
                        selAlt ? {24'h000000, alt_r} :
                        selRxd ? {24'h000000, rxData_r} :
                        selTxd ? {24'h000000, txData_r} : 32'h00000000;

    // bit level
    wire sclRise = bus.sclRise;
    wire sclFall = bus.sclFall;
    wire sda = bus.sdaLvl;
    wire [7:0] shNxt = {sh_r[6:0], sda};
    wire inRx = state_r == ST_RX;
    wire byteDone = inRx & sclRise & (bitCnt_r == 3'h7);

    wire is7Match = ~tenEn & (shNxt[7:1] == addr_r[6:0]);
    wire isTenHdr = tenEn & (shNxt[7:3] == i2c_slave_pkg::TEN_BIT_HDR) &
                    (shNxt[2:1] == addr_r[9:8]);
    wire tenWrite = isTenHdr & ~shNxt[0];
    wire tenRead = isTenHdr & shNxt[0] & tenMatched_r;
    wire isGcAddr = gcEn & (shNxt == i2c_slave_pkg::GC_ADDRESS);
    wire addr1Ack = is7Match | isGcAddr | tenWrite | tenRead;
    wire addr1Read = (is7Match & shNxt[0]) | tenRead;
    wire addr2Ack = shNxt == addr_r[7:0];
    wire dataAck = ~forceNoAck;
    wire ackDec = (phase_r == PH_ADDR1) ? addr1Ack :
                  (phase_r == PH_ADDR2) ? addr2Ack : dataAck;
    wire readDec = (phase_r == PH_ADDR1) & addr1Read & ~isGcAddr;
    wire gcByte = byteDone & (phase_r == PH_GC) & dataAck;
    wire gcReset = gcByte & (shNxt == i2c_slave_pkg::GC_RESET_CMD);
    wire gcProg = gcByte & (shNxt == i2c_slave_pkg::GC_PROG_CMD);
    wire gcHw = gcByte & hgcEn & gcEn & (shNxt == alt_r);
    wire gcAny = gcReset | gcProg | gcHw;
    wire [1:0] gcIdNew = gcReset ? i2c_slave_pkg::GCID_RESET :
                         gcProg ? i2c_slave_pkg::GCID_PROG : i2c_slave_pkg::GCID_HW;
    wire rxByte = byteDone & (phase_r == PH_DATA) & dataAck;
    wire masterAck = (state_r == ST_MACK) & sclRise & ~sda;
    wire txDone = (state_r == ST_MACK) & sclRise;
    wire txCause = (byteDone & readDec & ackDec) | masterAck;
    phase_e phaseAfter;
    assign phaseAfter = (phase_r == PH_ADDR1) ?
                        (isGcAddr ? PH_GC : (tenWrite ? PH_ADDR2 : PH_DATA)) : PH_DATA;

    // event routing into sticky status
    wire [4:0] evt;
    assign evt[i2c_slave_pkg::EV_TX_DONE] = txDone & ctrl_r[i2c_slave_pkg::CTL_SLAVE_TX_IRQ_EN];
    assign evt[i2c_slave_pkg::EV_RX_BYTE] = rxByte & ctrl_r[i2c_slave_pkg::CTL_SLAVE_RX_IRQ_EN];
    assign evt[i2c_slave_pkg::EV_STOP] = bus.stopDet & slvEn &
                                         ctrl_r[i2c_slave_pkg::CTL_STOP_DETECT_IRQ_EN];
    assign evt[i2c_slave_pkg::EV_GENCALL] = gcAny;
    assign evt[i2c_slave_pkg::EV_TX_REQ] = (early & txCause) | (txPend_r & sclFall);
    assign bus.evt = evt;
    assign bus.mask = mask_r;
    // only bits the read actually returned are cleared
    assign bus.clrMask = (access & ~pwrite & selStat) ? prdata_r[4:0] : 5'h00;

    // apb slave, no wait states: ready is raised in the first access cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & ~hit;
            if (setup) begin
                prdata_r <= pwrite ? 32'h00000000 : rdMux;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_r <= i2c_slave_pkg::CTL_RESET;
            mask_r <= i2c_slave_pkg::MASK_RESET;
            alt_r <= i2c_slave_pkg::ALT_RESET;
            txData_r <= 8'h00;
        end else if (wrAcc) begin
            if (selCtrl) begin
                ctrl_r <= pwdata[15:0] & i2c_slave_pkg::CTL_STORE_MASK;
            end
            if (selMask) begin
                mask_r <= pwdata[4:0];
            end
            if (selAlt) begin
                alt_r <= pwdata[7:0];
            end
            if (selTxd) begin
                txData_r <= pwdata[7:0];
            end
        end
    end

    // address pins settle through two flops before use
    always_ff @(posedge mclk) begin
        if (rst) begin
            pinS1_r <= 3'h0;
            pinS2_r <= 3'h0;
        end else begin
            pinS1_r <= addrPins;
            pinS2_r <= pinS1_r;
        end
    end

    // hardware load wins over a software write in the same cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            addr_r <= i2c_slave_pkg::ADDR_RESET;
        end else if (gcReset) begin
            addr_r[i2c_slave_pkg::ADDR_PROG_W-1:0] <= pinS2_r;
        end else if (wrAcc & selAddr) begin
            addr_r <= pwdata[9:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            gcStat_r <= 1'b0;
            gcId_r <= i2c_slave_pkg::GCID_NONE;
        end else if (gcAny) begin
            gcStat_r <= 1'b1;
            gcId_r <= gcIdNew;
        end else if (gcClrWr) begin
            gcStat_r <= 1'b0;
            gcId_r <= i2c_slave_pkg::GCID_NONE;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rxData_r <= 8'h00;
        end else if (rxByte | gcByte) begin
            rxData_r <= shNxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst | bus.stopDet | bus.startDet) begin
            txPend_r <= 1'b0;
        end else if (~early & txCause) begin
            txPend_r <= 1'b1;
        end else if (sclFall) begin
            txPend_r <= 1'b0;
        end
    end

    // byte engine
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            phase_r <= PH_ADDR1;
            sh_r <= 8'h00;
            bitCnt_r <= 3'h0;
            ackNow_r <= 1'b0;
            goTx_r <= 1'b0;
            goIdle_r <= 1'b0;
            readMode_r <= 1'b0;
            tenMatched_r <= 1'b0;
            sdaOe_r <= 1'b0;
            sdaOut_r <= 1'b0;
        end else if (~slvEn | bus.stopDet) begin
            state_r <= ST_IDLE;
            phase_r <= PH_ADDR1;
            sdaOe_r <= 1'b0;
            readMode_r <= 1'b0;
            tenMatched_r <= 1'b0;
        end else if (bus.startDet) begin
            // repeated start keeps the 10-bit match for a read header
            state_r <= ST_RX;
            phase_r <= PH_ADDR1;
            bitCnt_r <= 3'h0;
            sdaOe_r <= 1'b0;
            readMode_r <= 1'b0;
        end else begin
            case (state_r)
                ST_RX: begin
                    if (sclRise) begin
                        sh_r <= shNxt;
                        bitCnt_r <= bitCnt_r + 3'h1;
                    end
                    if (byteDone) begin
                        state_r <= ST_ACKW;
                        ackNow_r <= ackDec;
                        goTx_r <= readDec;
                        goIdle_r <= gcReset;
                        if (ackDec) begin
                            phase_r <= phaseAfter;
                        end
                        if (ackDec & (phase_r == PH_ADDR2)) begin
                            tenMatched_r <= 1'b1;
                        end
                    end
                end
                ST_ACKW: begin
                    if (sclFall) begin
                        sdaOe_r <= ackNow_r;
                        state_r <= ackNow_r ? ST_ACKD : ST_SKIP;
                    end
                end
                ST_ACKD: begin
                    if (sclFall) begin
                        bitCnt_r <= 3'h0;
                        if (goIdle_r) begin
                            state_r <= ST_IDLE;
                            phase_r <= PH_ADDR1;
                            tenMatched_r <= 1'b0;
                            sdaOe_r <= 1'b0;
                        end else if (goTx_r) begin
                            state_r <= ST_TX;
                            readMode_r <= 1'b1;
                            sh_r <= txData_r;
                            sdaOe_r <= ~txData_r[7];
                        end else begin
                            state_r <= ST_RX;
                            sdaOe_r <= 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (sclRise) begin
                        bitCnt_r <= bitCnt_r + 3'h1;
                        if (bitCnt_r == 3'h7) begin
                            state_r <= ST_TXACK;
                        end
                    end
                    if (sclFall) begin
                        sh_r <= {sh_r[6:0], 1'b0};
                        sdaOe_r <= ~sh_r[6];
                    end
                end
                ST_TXACK: begin
                    if (sclFall) begin
                        sdaOe_r <= 1'b0;
                        state_r <= ST_MACK;
                    end
                end
                ST_MACK: begin
                    if (sclRise) begin
                        // master ack asks for another byte
                        state_r <= sda ? ST_SKIP : ST_ACKD;
                        goTx_r <= 1'b1;
                        goIdle_r <= 1'b0;
                    end
                end
                ST_SKIP: begin
                    sdaOe_r <= 1'b0;
                end
                default: begin
                    sdaOe_r <= 1'b0;
                end
            endcase
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sdaOut = sdaOut_r;
    assign sdaOe = sdaOe_r;
    assign irq = bus.irq;
endmodule

// ==== sim/i2c_master_model.sv ====
`timescale 1ns/1ps
module i2c_master_model (
    output logic scl, // bus clock
    output logic sdaDrv, // master sda, 1 released
    input wire logic sda // resolved sda
);
    // quarter of the 160 ns bus clock
    localparam int Q = 40;
    logic r;
    initial begin
        scl = 1'h1;
        sdaDrv = 1'h1;
    end
    // data moves a quarter after scl falls, never beside it
    task automatic bitx(input logic b, output logic v);
        sdaDrv = b;
        #Q scl = 1'h1;
        #Q v = sda;
        #Q scl = 1'h0;
        #Q;
    endtask
    task automatic startCond();
        // stay off the mclk edges so pins never race the sync flops
        #2;
        #Q sdaDrv = 1'h0;
        #Q scl = 1'h0;
        #Q;
    endtask
    task automatic stopCond();
        sdaDrv = 1'h0;
        #Q scl = 1'h1;
        #Q sdaDrv = 1'h1;
        #Q;
    endtask
    task automatic wrByte(input logic [7:0] d, output logic k);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'h1, r);
        k = ~r;
    endtask
    task automatic xfer(input logic [7:0] b0, input logic [7:0] b1, output logic k0,
        output logic k1);
        startCond();
        wrByte(b0, k0);
        wrByte(b1, k1);
        stopCond();
    endtask
    task automatic rdXfer(input logic [7:0] a, output logic k, output logic [7:0] d);
        startCond();
        wrByte(a, k);
        for (int i = 7; i >= 0; i--) begin
            bitx(1'h1, d[i]);
        end
        bitx(1'h1, r);
        stopCond();
    endtask
endmodule

// ==== sim/i2c_slave_control_assertions.sv ====
`timescale 1ns/1ps
module i2c_slave_control_assertions (
    input wire logic mclk, // clock
    input wire logic rst, // reset
    input wire logic psel, // apb
    input wire logic penable, // apb
    input wire logic pwrite, // apb
    input wire logic [7:0] paddr, // apb
    input wire logic [31:0] pwdata, // apb
    input wire logic [31:0] prdata, // apb
    input wire logic pready, // apb
    input wire logic pslverr, // apb
    input wire logic sclIn, // link
    input wire logic sdaIn, // link
    input wire logic sdaOut, // link
    input wire logic sdaOe, // link
    input wire logic [2:0] addrPins, // address part
    input wire logic irq // interrupt
);
    logic [4:0] shadowMask_r;
    logic shadowEn_r;
    wire logic wrAcc = psel && penable && pready && pwrite;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    always_ff @(posedge mclk) begin
        if (rst) begin
            shadowMask_r <= 5'h00;
            shadowEn_r <= 1'h0;
        end else if (wrAcc && paddr == i2c_slave_pkg::OFF_MASK) begin
            shadowMask_r <= pwdata[4:0];
        end else if (wrAcc && paddr == i2c_slave_pkg::OFF_CTRL) begin
            shadowEn_r <= pwdata[0];
        end
    end
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (psel && !penable && paddr > i2c_slave_pkg::OFF_TXD
        |=> pslverr) else $error("unmapped not refused");
    drive_off_a: assert property (!shadowEn_r [*4] |-> !sdaOe)
        else $error("sda pulled while disabled");
    irq_masked_a: assert property ((shadowMask_r == 5'h00) [*3] |-> !irq)
        else $error("irq with all masked");
    irq_held_a: assert property (irq && !psel && !$past(psel) |=> irq)
        else $error("irq dropped unserviced");
    open_drain_a: assert property (!sdaOut)
        else $error("sda driven high");
    write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data on write");
    cover property ($rose(irq));
    cover property ($rose(sdaOe));
    cover property (pslverr);
endmodule
bind i2c_slave_control i2c_slave_control_assertions i2c_slave_control_assertions_inst (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrPins(addrPins),
    .irq(irq));

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic mclk, rst, psel, penable, pwrite, pready, pslverr, sdaOut, sdaOe, irq;
    logic [7:0] paddr, rb;
    logic [31:0] pwdata, prdata, q;
    logic [2:0] addrPins;
    logic scl, sdaDrv, a0, a1, err, lvl;
    int nChecks = 0;
    int miscompares = 0;
    // open drain: low if either side pulls
    wire logic sdaBus = sdaDrv & ~(sdaOe & ~sdaOut);
    i2c_slave_control i2c_slave_control_inst (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sclIn(scl), .sdaIn(sdaBus), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .addrPins(addrPins), .irq(irq));
    i2c_master_model i2c_master_model_inst (.scl(scl), .sdaDrv(sdaDrv), .sda(sdaBus));
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        nChecks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'h1);
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk(nm, e, q);
    endtask
    task automatic irqChk(input logic e);
        repeat (3) @(posedge mclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    task automatic xfer(input logic [7:0] b0, input logic [7:0] b1);
        i2c_master_model_inst.xfer(b0, b1, a0, a1);
        repeat (8) @(posedge mclk);
    endtask
    task automatic testRegs();
        rdChk("ctrl", i2c_slave_pkg::OFF_CTRL, 32'h0);
        rdChk("mask", i2c_slave_pkg::OFF_MASK, 32'h0);
        rdChk("addr", i2c_slave_pkg::OFF_ADDR, 32'h50);
        rdChk("alt", i2c_slave_pkg::OFF_ALT, 32'h1);
        apb(1'h1, i2c_slave_pkg::OFF_CTRL, 32'h07BF);
        rdChk("ctrl", i2c_slave_pkg::OFF_CTRL, 32'h7AF);
        rdChk("unmapped", 8'h40, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        apb(1'h1, i2c_slave_pkg::OFF_ALT, 32'h0B);
        $display("regs done");
    endtask
    task automatic testWrite();
        apb(1'h1, i2c_slave_pkg::OFF_CTRL, 32'h0);
        xfer(8'hA0, 8'h11);
        chk("off ack", 32'h0, {31'h0, a0});
        apb(1'h1, i2c_slave_pkg::OFF_CTRL, 32'h701);
        apb(1'h1, i2c_slave_pkg::OFF_MASK, 32'h1F);
        xfer(8'hA0, 8'hA5);
        chk("acks", 32'h3, {30'h0, a0, a1});
        irqChk(1'h1);
        rdChk("rxd", i2c_slave_pkg::OFF_RXD, 32'hA5);
        rdChk("stat", i2c_slave_pkg::OFF_STAT, 32'h6);
        irqChk(1'h0);
        $display("write done");
    endtask
    task automatic testNack();
        apb(1'h1, i2c_slave_pkg::OFF_CTRL, 32'h181);
        apb(1'h1, i2c_slave_pkg::OFF_MASK, 32'h0);
        xfer(8'hA0, 8'h5A);
        chk("acks", 32'h2, {30'h0, a0, a1});
        irqChk(1'h0);
        apb(1'h1, i2c_slave_pkg::OFF_MASK, 32'h4);
        irqChk(1'h1);
        rdChk("stat", i2c_slave_pkg::OFF_STAT, 32'h4);
        irqChk(1'h0);
        $display("nack done");
    endtask
    task automatic testRead();
        // late then early request: scl level when irq rises tells the edge
        for (int i = 0; i < 2; i++) begin
            apb(1'h1, i2c_slave_pkg::OFF_CTRL, i ? 32'h421 : 32'h401);
            apb(1'h1, i2c_slave_pkg::OFF_MASK, 32'h10);
            apb(1'h1, i2c_slave_pkg::OFF_TXD, 32'h3C);
            fork
                i2c_master_model_inst.rdXfer(8'hA1, a0, rb);
                begin
                    @(posedge irq);
                    lvl = scl;
                end
            join
            chk("tx byte", 32'h13C, {23'h0, a0, rb});
            chk("req edge", i ? 32'h1 : 32'h0, {31'h0, lvl});
            apb(1'h0, i2c_slave_pkg::OFF_STAT, 32'h0);
            chk("txdone", 32'h11, q & 32'h11);
            irqChk(1'h0);
        end
        apb(1'h1, i2c_slave_pkg::OFF_CTRL, 32'h3);
        xfer(8'hF0, 8'h50);
        chk("ten acks", 32'h3, {30'h0, a0, a1});
        $display("read done");
    endtask
    task automatic testGencall();
        logic [7:0] cmd [3] = '{8'h04, 8'h0B, 8'h06};
        logic [1:0] id [3] = '{2'h2, 2'h3, 2'h1};
        @(posedge mclk);
        addrPins <= 3'h5;
        for (int i = 0; i < 3; i++) begin
            apb(1'h1, i2c_slave_pkg::OFF_CTRL, 32'h10D);
            xfer(8'h00, cmd[i]);
            chk("gc ack", 32'h1, {31'h0, a0});
            apb(1'h0, i2c_slave_pkg::OFF_STAT, 32'h0);
            chk("gc stat", {24'h0, id[i], 6'h28}, q & 32'hE8);
            apb(1'h1, i2c_slave_pkg::OFF_CTRL, 32'h11D);
            rdChk("gc clear", i2c_slave_pkg::OFF_STAT, 32'h0);
        end
        rdChk("addr", i2c_slave_pkg::OFF_ADDR, 32'h55);
        $display("gencall done");
    endtask
    task automatic endOfTest();
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        rst = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        addrPins = 3'h0;
        repeat (16) @(posedge mclk);
        rst <= 1'h0;
        repeat (4) @(posedge mclk);
        testRegs();
        testWrite();
        testNack();
        testRead();
        testGencall();
        endOfTest();
    end
    // all tests need well under 100 us
    initial begin
        #500000;
        miscompares++;
        endOfTest();
    end
endmodule
